// *** hw/acf_action_filter.sv ***
// Top of the action command filter: AHB-Lite registers, matcher and router.
// Assumes messages arrive from a same-clock parser as one-cycle msgValid strobes,
// and a single AHB-Lite master issuing whole-word single transfers.
`timescale 1ns/1ps
`default_nettype none
module acf_action_filter (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        msgValid,
	input  wire logic [31:0] msgDeviceKey,
	input  wire logic [31:0] msgGroupKey,
	input  wire logic [31:0] msgGroupMask,
	output logic             actionPulse,
	output logic             frameBeginTrigger,
	output logic             captureBeginTrigger,
	output logic             rowBeginTrigger,
	output logic             counterClear
);
	// ****************************************
	// Declarations
	// ****************************************
	logic [31:0]                     authKey_r;
	logic [31:0]                     groupId_r;
	logic [31:0]                     subFilter_r;
	logic [31:0]                     slotSel_r;
	logic [3:0]                      trigCtrl_r;
	logic [acf_pkg::CNT_W-1:0]       accCnt_r;
	logic [acf_pkg::CNT_W-1:0]       rejCnt_r;
	logic                            wrPend_r;
	logic [acf_pkg::ADDR_W-1:0]      wrAddr_r;
	logic                            hreadyout_r;
	logic                            hresp_r;
	logic [31:0]                     hrdata_r;
	logic [31:0]                     rdMux;
	logic                            addrPhase;
	logic [acf_pkg::ADDR_W-1:0]      regAddr;
	logic                            regWr;
	acf_pkg::acf_trig_kind_t         trigKind;
	acf_msg_if                       msgBus ();

	// ****************************************
	// AHB-Lite slave
	// ****************************************
	// Zero wait states: read data is fetched in the address phase so that it
	// stands in the data phase without stalling the bus.
	assign addrPhase = hsel && hready && htrans[1];
	assign regAddr   = haddr[acf_pkg::ADDR_W-1:0];
	assign regWr     = wrPend_r;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wrPend_r <= 1'b0;
			wrAddr_r <= '0;
		end else begin
			if (hready) begin
				wrPend_r <= addrPhase && hwrite;
				wrAddr_r <= regAddr;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			hreadyout_r <= 1'b0;
			hresp_r     <= acf_pkg::HRESP_OKAY;
		end else begin
			hreadyout_r <= 1'b1;
			hresp_r     <= acf_pkg::HRESP_OKAY;
		end
	end

	always_comb begin
		case (regAddr)
			acf_pkg::ADDR_AUTH_KEY: begin
				rdMux = acf_pkg::ZERO_WORD;
			end
			acf_pkg::ADDR_GROUP_ID: begin
				rdMux = groupId_r;
			end
			acf_pkg::ADDR_SUB_FILTER: begin
				rdMux = subFilter_r;
			end
			acf_pkg::ADDR_SLOT_SEL: begin
				rdMux = slotSel_r;
			end
			acf_pkg::ADDR_TRIG_CTRL: begin
				rdMux = {28'h0000000, trigCtrl_r};
			end
			acf_pkg::ADDR_STATUS: begin
				rdMux = {29'h0000000, msgBus.checks};
			end
			acf_pkg::ADDR_ACC_CNT: begin
				rdMux = accCnt_r;
			end
			acf_pkg::ADDR_REJ_CNT: begin
				rdMux = rejCnt_r;
			end
			default: begin
				rdMux = acf_pkg::ZERO_WORD;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			hrdata_r <= acf_pkg::ZERO_WORD;
		end else begin
			if (addrPhase && !hwrite) begin
				hrdata_r <= rdMux;
			end
		end
	end

	// ****************************************
	// Configuration registers
	// ****************************************
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			authKey_r <= acf_pkg::RST_AUTH_KEY;
		end else begin
			if (regWr && wrAddr_r == acf_pkg::ADDR_AUTH_KEY) begin
				authKey_r <= hwdata;
			end
		end
	end

	// A single group register: membership is replaced, never accumulated
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			groupId_r <= acf_pkg::RST_GROUP_ID;
		end else begin
			if (regWr && wrAddr_r == acf_pkg::ADDR_GROUP_ID) begin
				groupId_r <= hwdata;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			subFilter_r <= acf_pkg::RST_SUB_FILTER;
		end else begin
			if (regWr && wrAddr_r == acf_pkg::ADDR_SUB_FILTER) begin
				subFilter_r <= hwdata;
			end
		end
	end

	// Any value other than the one slot disables execution
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			slotSel_r <= acf_pkg::RST_SLOT_SEL;
		end else begin
			if (regWr && wrAddr_r == acf_pkg::ADDR_SLOT_SEL) begin
				slotSel_r <= hwdata;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			trigCtrl_r <= acf_pkg::RST_TRIG_CTRL;
		end else begin
			if (regWr && wrAddr_r == acf_pkg::ADDR_TRIG_CTRL) begin
				trigCtrl_r <= hwdata[3:0];
			end
		end
	end

	// ****************************************
	// Message statistics
	// ****************************************
	// Counters wrap; software takes differences
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			accCnt_r <= '0;
			rejCnt_r <= '0;
		end else begin
			if (msgBus.hit) begin
				accCnt_r <= accCnt_r + acf_pkg::CNT_ONE;
			end
			if (msgBus.miss) begin
				rejCnt_r <= rejCnt_r + acf_pkg::CNT_ONE;
			end
		end
	end

	// ****************************************
	// Matching and routing
	// ****************************************
	assign msgBus.msgValid  = msgValid;
	assign msgBus.deviceKey = msgDeviceKey;
	assign msgBus.groupKey  = msgGroupKey;
	assign msgBus.groupMask = msgGroupMask;
	assign trigKind = acf_pkg::acf_trig_kind_t'(trigCtrl_r[acf_pkg::TC_KIND_HI:acf_pkg::TC_KIND_LO]);

	acf_matcher u_matcher (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.authKey   (authKey_r),
		.groupId   (groupId_r),
		.subFilter (subFilter_r),
		.slotSel   (slotSel_r),
		.msg       (msgBus.matcher)
	);

	acf_router u_router (
		.mclk                         (mclk),
		.rst_n                        (rst_n),
		.hit                          (msgBus.hit),
		.triggerKindSelect            (trigKind),
		.triggerFromActionSignal      (trigCtrl_r[acf_pkg::TC_TRIG_SRC]),
		.counterClearFromActionSignal (trigCtrl_r[acf_pkg::TC_CLR_SRC]),
		.actionPulse_r                (actionPulse),
		.frameBeginTrigger_r          (frameBeginTrigger),
		.captureBeginTrigger_r        (captureBeginTrigger),
		.rowBeginTrigger_r            (rowBeginTrigger),
		.counterClear_r               (counterClear)
	);

	assign hreadyout = hreadyout_r;
	assign hresp     = hresp_r;
	assign hrdata    = hrdata_r;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence s_key_read;
		addrPhase && !hwrite && (regAddr == acf_pkg::ADDR_AUTH_KEY);
	endsequence

	property p_key_hidden;
		s_key_read |=> (hrdata == acf_pkg::ZERO_WORD);
	endproperty
	a_key_hidden: assert property (p_key_hidden) else $error("key readable");

	property p_group_replace;
		regWr && (wrAddr_r == acf_pkg::ADDR_GROUP_ID) |=> (groupId_r == $past(hwdata));
	endproperty
	a_group_replace: assert property (p_group_replace) else $error("group not replaced");

	sequence s_good_msg;
		msgValid && (msgDeviceKey == authKey_r) && (msgGroupKey == groupId_r)
			&& ((msgGroupMask & subFilter_r) != 32'h0) && (slotSel_r == acf_pkg::ACTION_SLOT);
	endsequence

	property p_pulse_after_hit;
		s_good_msg |-> ##2 actionPulse;
	endproperty
	a_pulse_after_hit: assert property (p_pulse_after_hit) else $error("no action pulse");

	property p_pulse_single;
		actionPulse |-> $past(msgValid, 2);
	endproperty
	a_pulse_single: assert property (p_pulse_single) else $error("pulse without message");

	property p_zero_filter;
		(subFilter_r == 32'h0) && msgValid |-> ##2 !actionPulse;
	endproperty
	a_zero_filter: assert property (p_zero_filter) else $error("zero filter matched");

	property p_reject_count;
		msgBus.miss |=> (rejCnt_r == $past(rejCnt_r) + acf_pkg::CNT_ONE);
	endproperty
	a_reject_count: assert property (p_reject_count) else $error("reject not counted");

	property p_clear_after_hit;
		s_good_msg ##0 trigCtrl_r[acf_pkg::TC_CLR_SRC] |-> ##2 counterClear;
	endproperty
	a_clear_after_hit: assert property (p_clear_after_hit) else $error("no counter clear");

	property p_capture_after_hit;
		s_good_msg ##0 (trigCtrl_r[acf_pkg::TC_TRIG_SRC] && (trigKind == acf_pkg::ACF_KIND_CAPTURE))
			|-> ##2 captureBeginTrigger;
	endproperty
	a_capture_after_hit: assert property (p_capture_after_hit) else $error("no capture trigger");
endmodule : acf_action_filter
`default_nettype wire

// *** hw/acf_matcher.sv ***
// Compares a received action message against the stored key, group and filter.
// Assumes configuration registers are stable in the message cycle.
`timescale 1ns/1ps
`default_nettype none
module acf_matcher (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic [31:0] authKey,
	input  wire logic [31:0] groupId,
	input  wire logic [31:0] subFilter,
	input  wire logic [31:0] slotSel,
	acf_msg_if.matcher       msg
);
	logic keyOk;
	logic groupOk;
	logic maskOk;
	logic allOk;

	assign keyOk   = (msg.deviceKey == authKey);
	assign groupOk = (msg.groupKey == groupId);
	// A zero filter has no common bit, so it never matches
	assign maskOk  = |(msg.groupMask & subFilter);
	assign allOk   = keyOk && groupOk && maskOk && (slotSel == acf_pkg::ACTION_SLOT);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			msg.hit    <= 1'b0;
			msg.miss   <= 1'b0;
			msg.checks <= 3'h0;
		end else begin
			msg.hit  <= msg.msgValid && allOk;
			msg.miss <= msg.msgValid && !allOk;
			if (msg.msgValid) begin
				msg.checks <= {maskOk, groupOk, keyOk};
			end
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	property p_key_gate;
		msg.msgValid && (msg.deviceKey != authKey) |=> !msg.hit;
	endproperty
	a_key_gate: assert property (p_key_gate) else $error("hit with wrong key");

	property p_group_gate;
		msg.msgValid && (msg.groupKey != groupId) |=> !msg.hit;
	endproperty
	a_group_gate: assert property (p_group_gate) else $error("hit with wrong group");

	property p_mask_gate;
		msg.msgValid && ((msg.groupMask & subFilter) == 32'h0) |=> !msg.hit && msg.miss;
	endproperty
	a_mask_gate: assert property (p_mask_gate) else $error("hit with no common bit");

	property p_hit_needs_all;
		msg.hit |-> $past(msg.msgValid) && $past(keyOk) && $past(groupOk) && $past(maskOk);
	endproperty
	a_hit_needs_all: assert property (p_hit_needs_all) else $error("hit without all checks");
endmodule : acf_matcher
`default_nettype wire

// *** hw/acf_msg_if.sv ***
// Interface carrying one received action message and the filter verdict.
// Assumes the message fields are valid for the single cycle msgValid is high.
`timescale 1ns/1ps
`default_nettype none
interface acf_msg_if;
	logic        msgValid;
	logic [31:0] deviceKey;
	logic [31:0] groupKey;
	logic [31:0] groupMask;
	logic        hit;
	logic        miss;
	logic [2:0]  checks;

	modport source (output msgValid, deviceKey, groupKey, groupMask, input hit, miss, checks);
	modport matcher (input msgValid, deviceKey, groupKey, groupMask, output hit, miss, checks);
endinterface : acf_msg_if
`default_nettype wire

// *** hw/acf_pkg.sv ***
// Constants shared by the action command filter: register map, fields, bus codes.
// Assumes a 32-bit AHB-Lite register bus and a single mclk domain.
package acf_pkg;

	// ****************************************
	// Widths
	// ****************************************
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned CNT_W  = 32;

	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [ADDR_W-1:0] ADDR_AUTH_KEY   = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_GROUP_ID   = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_SUB_FILTER = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_SLOT_SEL   = 8'h0c;
	localparam logic [ADDR_W-1:0] ADDR_TRIG_CTRL  = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_STATUS     = 8'h14;
	localparam logic [ADDR_W-1:0] ADDR_ACC_CNT    = 8'h18;
	localparam logic [ADDR_W-1:0] ADDR_REJ_CNT    = 8'h1c;

	// ****************************************
	// Reset values and fixed compare and count constants
	// ****************************************
	localparam logic [DATA_W-1:0] RST_AUTH_KEY   = 32'h0000_0000;
	localparam logic [DATA_W-1:0] RST_GROUP_ID   = 32'h0000_0000;
	localparam logic [DATA_W-1:0] RST_SUB_FILTER = 32'h0000_0000;
	localparam logic [DATA_W-1:0] RST_SLOT_SEL   = 32'h0000_0001;
	localparam logic [DATA_W-1:0] ACTION_SLOT    = 32'h0000_0001;
	localparam logic [DATA_W-1:0] ZERO_WORD      = 32'h0000_0000;
	localparam logic [CNT_W-1:0]  CNT_ONE        = 32'h0000_0001;

	// ****************************************
	// Trigger control fields
	// ****************************************
	localparam int unsigned TC_KIND_LO  = 0;
	localparam int unsigned TC_KIND_HI  = 1;
	localparam int unsigned TC_TRIG_SRC = 2;
	localparam int unsigned TC_CLR_SRC  = 3;
	localparam logic [3:0]  RST_TRIG_CTRL = 4'h0;

	typedef enum logic [1:0] {
		ACF_KIND_FRAME   = 2'b00,
		ACF_KIND_CAPTURE = 2'b01,
		ACF_KIND_ROW     = 2'b10
	} acf_trig_kind_t;

	// Status: which checks the last message passed
	localparam int unsigned ST_KEY_OK   = 0;
	localparam int unsigned ST_GROUP_OK = 1;
	localparam int unsigned ST_MASK_OK  = 2;

	// ****************************************
	// AHB-Lite codes
	// ****************************************
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic       HRESP_OKAY    = 1'h0;

endpackage : acf_pkg

// *** hw/acf_router.sv ***
// Routes the single action signal to the selected trigger and counter clear.
// Assumes hit is a one-cycle pulse per accepted message.
`timescale 1ns/1ps
`default_nettype none
module acf_router (
	input  wire logic                    mclk,
	input  wire logic                    rst_n,
	input  wire logic                    hit,
	input  wire acf_pkg::acf_trig_kind_t triggerKindSelect,
	input  wire logic                    triggerFromActionSignal,
	input  wire logic                    counterClearFromActionSignal,
	output logic                         actionPulse_r,
	output logic                         frameBeginTrigger_r,
	output logic                         captureBeginTrigger_r,
	output logic                         rowBeginTrigger_r,
	output logic                         counterClear_r
);
	logic trigHit;

	assign trigHit = hit && triggerFromActionSignal;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			actionPulse_r <= 1'b0;
		end else begin
			actionPulse_r <= hit;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			frameBeginTrigger_r   <= 1'b0;
			captureBeginTrigger_r <= 1'b0;
			rowBeginTrigger_r     <= 1'b0;
		end else begin
			// Unused kind code drives no trigger
			frameBeginTrigger_r   <= trigHit && (triggerKindSelect == acf_pkg::ACF_KIND_FRAME);
			captureBeginTrigger_r <= trigHit && (triggerKindSelect == acf_pkg::ACF_KIND_CAPTURE);
			rowBeginTrigger_r     <= trigHit && (triggerKindSelect == acf_pkg::ACF_KIND_ROW);
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			counterClear_r <= 1'b0;
		end else begin
			counterClear_r <= hit && counterClearFromActionSignal;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	property p_frame_route;
		trigHit && (triggerKindSelect == acf_pkg::ACF_KIND_FRAME)
			|=> frameBeginTrigger_r && !captureBeginTrigger_r && !rowBeginTrigger_r;
	endproperty
	a_frame_route: assert property (p_frame_route) else $error("frame trigger not routed");

	property p_clear_route;
		hit && counterClearFromActionSignal |=> counterClear_r ##1 (!counterClear_r || $past(hit));
	endproperty
	a_clear_route: assert property (p_clear_route) else $error("counter clear not routed");
endmodule : acf_router
`default_nettype wire

// *** test/acf_action_filter_tb.sv ***
// Self-checking bench for the action command filter.
// Assumes zero-wait AHB-Lite slave and a two-edge message-to-pulse latency.
`timescale 1ns/1ps
`default_nettype none
module acf_action_filter_tb;
	typedef struct {time t; logic [4:0] outs;} acf_exp_t;

	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0000_0000;
	wire         hreadyout;
	wire         hresp;
	wire  [31:0] hrdata;
	wire         msgValid;
	wire  [31:0] msgDeviceKey;
	wire  [31:0] msgGroupKey;
	wire  [31:0] msgGroupMask;
	wire         actionPulse;
	wire         frameBeginTrigger;
	wire         captureBeginTrigger;
	wire         rowBeginTrigger;
	wire         counterClear;
	int          errors = 0;
	int          num_checks = 0;
	logic [31:0] seed = 32'h0000_0005;
	logic [31:0] key, grp, filt, slot, accCnt, rejCnt;
	logic [1:0]  kind;
	logic        trigSrc, clrSrc;
	acf_exp_t    expQ[$];

	always #25 mclk = ~mclk;

	acf_action_filter dut (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.msgValid(msgValid), .msgDeviceKey(msgDeviceKey), .msgGroupKey(msgGroupKey),
		.msgGroupMask(msgGroupMask), .actionPulse(actionPulse),
		.frameBeginTrigger(frameBeginTrigger), .captureBeginTrigger(captureBeginTrigger),
		.rowBeginTrigger(rowBeginTrigger), .counterClear(counterClear));

	acf_host_model host (.mclk(mclk), .msgValid(msgValid), .msgDeviceKey(msgDeviceKey),
		.msgGroupKey(msgGroupKey), .msgGroupMask(msgGroupMask));

	// ****************************************
	// Checking and verdict
	// ****************************************
	task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", name, e, g);
		end
	endtask : chk

	task automatic print_verdict();
		if (errors == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	// Any output activity must match the oldest pending note
	always @(posedge mclk) begin : mon
		acf_exp_t   e;
		logic [4:0] seen;
		seen = {actionPulse, frameBeginTrigger, captureBeginTrigger, rowBeginTrigger,
			counterClear};
		if (seen !== 5'h00) begin
			if (expQ.size() == 0) begin
				chk("unexpected outputs", 32'h0000_0000, {27'h0, seen});
			end else begin
				e = expQ.pop_front();
				chk("pulse time", 32'(e.t), 32'($time));
				chk("pulse outputs", {27'h0, e.outs}, {27'h0, seen});
			end
		end
	end

	// ****************************************
	// AHB-Lite master
	// ****************************************
	task automatic ahbAddr(input logic [7:0] a, input logic w);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= acf_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
	endtask : ahbAddr

	task automatic ahbWr(input logic [7:0] a, input logic [31:0] d);
		ahbAddr(a, 1'b1);
		hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'b1);
	endtask : ahbWr

	task automatic rdChk(input string name, input logic [7:0] a, input logic [31:0] e);
		ahbAddr(a, 1'b0);
		do @(posedge mclk); while (hreadyout !== 1'b1);
		chk(name, e, hrdata);
		chk("hresp", {31'h0, acf_pkg::HRESP_OKAY}, {31'h0, hresp});
	endtask : rdChk

	task automatic cfgTrig(input logic [1:0] k, input logic s, input logic c);
		kind    = k;
		trigSrc = s;
		clrSrc  = c;
		ahbWr(acf_pkg::ADDR_TRIG_CTRL, {28'h0, c, s, k});
	endtask : cfgTrig

	// ****************************************
	// Messages and their expected outcome
	// ****************************************
	task automatic msg(input logic [31:0] k, input logic [31:0] g, input logic [31:0] m);
		host.send(k, g, m);
		if (k === key && g === grp && (m & filt) !== 32'h0 && slot === 32'h1) begin
			expQ.push_back('{$time + 100, {1'b1, trigSrc && kind == 2'd0,
				trigSrc && kind == 2'd1, trigSrc && kind == 2'd2, clrSrc}});
			accCnt++;
		end else begin
			rejCnt++;
		end
	endtask : msg

	task automatic settle();
		host.idle();
		repeat (4) @(posedge mclk);
	endtask : settle

	initial begin : watchdog
		repeat (20000) @(posedge mclk);
		errors++;
		print_verdict();
	end

	initial begin
		accCnt = 32'h0;
		rejCnt = 32'h0;
		slot   = 32'h1;
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		rdChk("group reset", acf_pkg::ADDR_GROUP_ID, 32'h0000_0000);
		rdChk("filter reset", acf_pkg::ADDR_SUB_FILTER, 32'h0000_0000);
		rdChk("slot reset", acf_pkg::ADDR_SLOT_SEL, 32'h0000_0001);
		rdChk("trig reset", acf_pkg::ADDR_TRIG_CTRL, 32'h0000_0000);
		chk("broadcast dest", 32'h1, 32'(host.DEST == "255.255.255.255"));
		key  = xs();
		grp  = xs();
		filt = xs() | 32'h0000_0001;
		ahbWr(acf_pkg::ADDR_AUTH_KEY, key);
		rdChk("auth key read", acf_pkg::ADDR_AUTH_KEY, 32'h0000_0000);
		ahbWr(8'h20, xs());
		rdChk("unmapped read", 8'h20, 32'h0000_0000);
		ahbWr(acf_pkg::ADDR_GROUP_ID, ~grp);
		ahbWr(acf_pkg::ADDR_GROUP_ID, grp);
		rdChk("group replace", acf_pkg::ADDR_GROUP_ID, grp);
		ahbWr(acf_pkg::ADDR_SUB_FILTER, filt);
		rdChk("filter", acf_pkg::ADDR_SUB_FILTER, filt);
		ahbWr(acf_pkg::ADDR_SLOT_SEL, 32'h0000_0001);
		for (int i = 0; i < 6; i++) begin
			cfgTrig(i[1:0], i < 4, i[0]);
			msg(key, grp, filt);
			settle();
		end
		msg(key ^ (32'h1 << (xs() % 32)), grp, filt);
		msg(key, grp ^ (32'h1 << (xs() % 32)), filt);
		msg(key, grp, ~filt);
		msg(key, grp, filt);
		msg(key, grp, filt);
		settle();
		for (int i = 0; i < 24; i++) begin
			msg(i % 5 == 0 ? xs() : key, i % 7 == 0 ? xs() : grp, xs() & xs());
		end
		settle();
		rdChk("accepted count", acf_pkg::ADDR_ACC_CNT, accCnt);
		rdChk("rejected count", acf_pkg::ADDR_REJ_CNT, rejCnt);
		filt = 32'h0000_0000;
		ahbWr(acf_pkg::ADDR_SUB_FILTER, filt);
		msg(key, grp, 32'hffff_ffff);
		settle();
		filt = 32'hffff_ffff;
		slot = 32'h0000_0002;
		ahbWr(acf_pkg::ADDR_SUB_FILTER, filt);
		ahbWr(acf_pkg::ADDR_SLOT_SEL, slot);
		msg(key, grp, 32'h0000_0001);
		settle();
		// Last message passed all three checks; only the slot blocked it
		rdChk("status", acf_pkg::ADDR_STATUS, 32'h0000_0007);
		chk("pending results", 32'h0, 32'(expQ.size()));
		print_verdict();
	end
endmodule : acf_action_filter_tb
`default_nettype wire

// *** test/acf_host_model.sv ***
// Host model: broadcasts action messages toward the filter.
// Assumes the bench calls send right after a rising mclk edge.
`timescale 1ns/1ps
`default_nettype none
module acf_host_model #(
	parameter string DEST = "255.255.255.255"
) (
	input  wire logic  mclk,
	output logic        msgValid,
	output logic [31:0] msgDeviceKey,
	output logic [31:0] msgGroupKey,
	output logic [31:0] msgGroupMask
);
	initial begin
		msgValid     = 1'b0;
		msgDeviceKey = 32'h0000_0000;
		msgGroupKey  = 32'h0000_0000;
		msgGroupMask = 32'h0000_0000;
	end

	// ****************************************
	// One message: all three fields together
	// ****************************************
	task automatic send(input logic [31:0] k, input logic [31:0] g, input logic [31:0] m);
		msgValid     <= 1'b1;
		msgDeviceKey <= k;
		msgGroupKey  <= g;
		msgGroupMask <= m;
		@(posedge mclk);
	endtask : send

	// Released fields show garbage, never the last message
	task automatic idle();
		msgValid     <= 1'b0;
		msgDeviceKey <= ~msgDeviceKey;
		msgGroupKey  <= ~msgGroupKey;
		msgGroupMask <= ~msgGroupMask;
	endtask : idle
endmodule : acf_host_model
`default_nettype wire
